/* core/sbg_pkg.sv */
/*
  Package for the serial port with baud generator: prescaler codes,
  reset values and frame counts. Assumes an 8-bit data frame, one stop bit.
*/
package sbg_pkg;
  localparam logic [1:0] SBG_PS_DIV1 = 2'h0;
  localparam logic [1:0] SBG_PS_DIV4 = 2'h1;
  localparam logic [1:0] SBG_PS_DIV12 = 2'h2;
  localparam logic [1:0] SBG_PS_DIV48 = 2'h3;
  localparam logic [5:0] SBG_PS_CNT1 = 6'h00;
  localparam logic [5:0] SBG_PS_CNT4 = 6'h03;
  localparam logic [5:0] SBG_PS_CNT12 = 6'h0b;
  localparam logic [5:0] SBG_PS_CNT48 = 6'h2f;
  localparam logic [15:0] SBG_RELOAD_RST = 16'h0000;
  localparam logic [15:0] SBG_TIMER_MAX = 16'hffff;
  localparam logic [7:0] SBG_BYTE_RST = 8'h00;
  localparam logic [3:0] SBG_OVS = 4'h1;
  localparam logic [3:0] SBG_DATA_BITS = 4'h8;
  localparam logic [1:0] SBG_FIFO_DEPTH = 2'h3;
  localparam logic [1:0] SBG_FIFO_ZERO = 2'h0;
endpackage

/* core/sbg_tick_if.sv */
/*
  Interface carrying the baud tick and its configuration between the
  generator and the serial port core. Assumes one clock domain.
*/
`timescale 1ns/1ps
interface sbg_tick_if;
  logic enable;
  logic use_usb;
  logic [1:0] prescaler_select;
  logic [15:0] reload;
  logic half_tick;
  modport gen (input enable, input use_usb, input prescaler_select, input reload,
    output half_tick);
  modport core (output enable, output use_usb, output prescaler_select, output reload,
    input half_tick);
endinterface

/* core/sbg_baud_gen.sv */
/*
  Baud generator: prescaler and 16-bit reload timer, one half-bit tick per
  overflow. Assumes usb_clock is already synchronised to clock.
*/
`timescale 1ns/1ps
module sbg_baud_gen (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic usb_tick,
  sbg_tick_if.gen bus
);
  import sbg_pkg::*;
  logic [5:0] ps_q, ps_d;
  logic [15:0] tmr_q, tmr_d;
  logic run_q, run_d;
  logic tick_q, tick_d;
  logic src;
  logic [5:0] ps_lim;

  always_comb begin
    src = bus.use_usb ? usb_tick : 1'b1;
    unique case (bus.prescaler_select)
      SBG_PS_DIV1: ps_lim = SBG_PS_CNT1;
      SBG_PS_DIV4: ps_lim = SBG_PS_CNT4;
      SBG_PS_DIV12: ps_lim = SBG_PS_CNT12;
      SBG_PS_DIV48: ps_lim = SBG_PS_CNT48;
    endcase
    ps_d = ps_q;
    tmr_d = tmr_q;
    tick_d = 1'b0;
    run_d = bus.enable;
    if (!bus.enable) begin
      ps_d = 6'h00;
    end else if (!run_q) begin
      tmr_d = bus.reload;
    end else if (src) begin
      if (ps_q >= ps_lim) begin
        ps_d = 6'h00;
        if (tmr_q == SBG_TIMER_MAX) begin
          tmr_d = bus.reload;
          tick_d = 1'b1;
        end else begin
          tmr_d = tmr_q + 16'h0001;
        end
      end else begin
        ps_d = ps_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ps_q <= 6'h00;
      tmr_q <= SBG_RELOAD_RST;
      run_q <= 1'b0;
      tick_q <= 1'b0;
    end else if (clock_enable) begin
      ps_q <= ps_d;
      tmr_q <= tmr_d;
      run_q <= run_d;
      tick_q <= tick_d;
    end
  end
  assign bus.half_tick = tick_q;
endmodule

/* core/sbg_serial_port.sv */
/*
  Serial port with dedicated baud generator: transmitter, receiver with a
  three-byte FIFO, flags cleared by software. Assumes 8N1 frames and that
  software and rx pin are the only stimulus; rx passes two flip-flops.
*/
`timescale 1ns/1ps
module sbg_serial_port (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic usb_clock,
  input wire logic gen_enable,
  input wire logic gen_use_usb,
  input wire logic [1:0] prescaler_select,
  input wire logic [7:0] baud_reload_high,
  input wire logic [7:0] baud_reload_low,
  input wire logic receive_enable,
  input wire logic irq_enable,
  input wire logic buf_write,
  input wire logic [7:0] buf_wdata,
  input wire logic buf_read,
  input wire logic clear_tx_flag,
  input wire logic clear_rx_flag,
  input wire logic clear_overrun,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic [7:0] buf_rdata,
  output logic transmit_complete_flag,
  output logic receive_flag,
  output logic receive_overrun_flag,
  output logic tx_busy,
  output logic irq
);
  import sbg_pkg::*;
  typedef enum logic [2:0] {
    SBG_IDLE = 3'b001, SBG_DATA = 3'b010, SBG_STOP = 3'b100
  } sbg_state_t;

  sbg_tick_if tk ();
  assign tk.enable = gen_enable;
  assign tk.use_usb = gen_use_usb;
  assign tk.prescaler_select = prescaler_select;
  assign tk.reload = {baud_reload_high, baud_reload_low};

  // Two stages each for the pins; usb edge found after the second stage
  logic rx_m_q, rx_s_q, ub_m_q, ub_s_q, ub_p_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
      ub_m_q <= 1'b0;
      ub_s_q <= 1'b0;
      ub_p_q <= 1'b0;
    end else if (clock_enable) begin
      rx_m_q <= rx_pin;
      rx_s_q <= rx_m_q;
      ub_m_q <= usb_clock;
      ub_s_q <= ub_m_q;
      ub_p_q <= ub_s_q;
    end
  end

  sbg_baud_gen u_gen (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .usb_tick(ub_s_q & ~ub_p_q),
    .bus(tk.gen)
  );

  // Two half ticks make one bit
  logic tx_ph_q, tx_ph_d;
  logic tx_bit;
  assign tx_bit = tk.half_tick & tx_ph_q;

  // Transmitter; a write while busy is dropped
  sbg_state_t ts_q, ts_d;
  logic [8:0] tsh_q, tsh_d;
  logic [3:0] tcnt_q, tcnt_d;
  logic tx_q, tx_d, tif_q, tif_d;
  always_comb begin
    ts_d = ts_q;
    tsh_d = tsh_q;
    tcnt_d = tcnt_q;
    tx_d = tx_q;
    tif_d = tif_q & ~clear_tx_flag;
    tx_ph_d = tk.half_tick ? ~tx_ph_q : tx_ph_q;
    unique case (ts_q)
      SBG_IDLE: begin
        tx_d = 1'b1;
        if (buf_write && gen_enable) begin
          tsh_d = {buf_wdata, 1'b0};
          tcnt_d = 4'h0;
          ts_d = SBG_DATA;
          tx_ph_d = 1'b0;
        end
      end
      SBG_DATA: begin
        tx_d = tsh_q[0];
        if (tx_bit) begin
          tsh_d = {1'b1, tsh_q[8:1]};
          tcnt_d = tcnt_q + 4'h1;
          if (tcnt_q == SBG_DATA_BITS) begin
            ts_d = SBG_STOP;
            tx_d = 1'b1;
            tif_d = 1'b1;
          end
        end
      end
      SBG_STOP: begin
        tx_d = 1'b1;
        if (tx_bit) begin
          ts_d = SBG_IDLE;
        end
      end
    endcase
    if (!gen_enable) begin
      ts_d = SBG_IDLE;
    end
  end

  // Receiver: half tick is mid-bit sampling granularity
  sbg_state_t rs_q, rs_d;
  logic [7:0] rsh_q, rsh_d;
  logic [3:0] rcnt_q, rcnt_d;
  logic [1:0] rph_q, rph_d;
  logic rx_done, rx_tick;
  always_comb begin
    rs_d = rs_q;
    rsh_d = rsh_q;
    rcnt_d = rcnt_q;
    rph_d = rph_q;
    rx_done = 1'b0;
    rx_tick = 1'b0;
    if (tk.half_tick) begin
      rph_d = rph_q + 2'h1;
      rx_tick = rph_q[0];
    end
    unique case (rs_q)
      SBG_IDLE: begin
        if (receive_enable && gen_enable && !rx_s_q) begin
          rs_d = SBG_DATA;
          rcnt_d = 4'h0;
          rph_d = 2'h0;
        end
      end
      SBG_DATA: begin
        if (rx_tick) begin
          rcnt_d = rcnt_q + 4'h1;
          if (rcnt_q != 4'h0) begin
            rsh_d = {rx_s_q, rsh_q[7:1]};
          end else if (rx_s_q) begin
            rs_d = SBG_IDLE;
          end
          if (rcnt_q == SBG_DATA_BITS) begin
            rs_d = SBG_STOP;
          end
        end
      end
      SBG_STOP: begin
        if (rx_tick) begin
          rs_d = SBG_IDLE;
          rx_done = rx_s_q;
        end
      end
    endcase
    if (!gen_enable) begin
      rs_d = SBG_IDLE;
    end
  end

  // Receive FIFO; slot 0 is the byte the buffer location shows
  logic [7:0] fifo_q [3];
  logic [7:0] fifo_d [3];
  logic [1:0] cnt_q, cnt_d;
  logic rif_q, rif_d, ovr_q, ovr_d;
  logic pop;
  always_comb begin
    fifo_d = fifo_q;
    cnt_d = cnt_q;
    ovr_d = ovr_q & ~clear_overrun;
    pop = buf_read && (cnt_q != SBG_FIFO_ZERO);
    if (pop) begin
      fifo_d[0] = fifo_q[1];
      fifo_d[1] = fifo_q[2];
      cnt_d = cnt_q - 2'h1;
    end
    rif_d = rif_q;
    if (clear_rx_flag && (cnt_d == SBG_FIFO_ZERO || (cnt_d == 2'h1 && !pop))) begin
      rif_d = 1'b0;
    end
    if (rx_done) begin
      if (cnt_q == SBG_FIFO_DEPTH && !pop) begin
        ovr_d = 1'b1;
      end else begin
        fifo_d[cnt_d] = rsh_q;
        cnt_d = cnt_d + 2'h1;
        rif_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ts_q <= SBG_IDLE;
      tsh_q <= 9'h1ff;
      tcnt_q <= 4'h0;
      tx_q <= 1'b1;
      tif_q <= 1'b0;
      tx_ph_q <= 1'b0;
      rs_q <= SBG_IDLE;
      rsh_q <= SBG_BYTE_RST;
      rcnt_q <= 4'h0;
      rph_q <= 2'h0;
      fifo_q <= '{default: SBG_BYTE_RST};
      cnt_q <= SBG_FIFO_ZERO;
      rif_q <= 1'b0;
      ovr_q <= 1'b0;
    end else if (clock_enable) begin
      ts_q <= ts_d;
      tsh_q <= tsh_d;
      tcnt_q <= tcnt_d;
      tx_q <= tx_d;
      tif_q <= tif_d;
      tx_ph_q <= tx_ph_d;
      rs_q <= rs_d;
      rsh_q <= rsh_d;
      rcnt_q <= rcnt_d;
      rph_q <= rph_d;
      fifo_q <= fifo_d;
      cnt_q <= cnt_d;
      rif_q <= rif_d;
      ovr_q <= ovr_d;
    end
  end

  // Outputs registered once more so all come from flip-flops
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_pin <= 1'b1;
      buf_rdata <= SBG_BYTE_RST;
      transmit_complete_flag <= 1'b0;
      receive_flag <= 1'b0;
      receive_overrun_flag <= 1'b0;
      tx_busy <= 1'b0;
      irq <= 1'b0;
    end else if (clock_enable) begin
      tx_pin <= tx_d;
      buf_rdata <= fifo_d[0];
      transmit_complete_flag <= tif_d;
      receive_flag <= rif_d;
      receive_overrun_flag <= ovr_d;
      tx_busy <= (ts_d != SBG_IDLE);
      irq <= irq_enable & (tif_d | rif_d);
    end
  end

  AST_TIF_STOP: assert property (@(posedge clock) disable iff (reset)
    clock_enable && $rose(tif_q) |-> ts_q == SBG_STOP && tx_q)
    else $error("transmit flag rose outside stop");
  AST_RIF_HOLD: assert property (@(posedge clock) disable iff (reset)
    clock_enable && rif_q && cnt_q >= 2'h2 |=> rif_q)
    else $error("receive flag cleared with bytes left");
  AST_OVR: assert property (@(posedge clock) disable iff (reset)
    clock_enable && rx_done && cnt_q == SBG_FIFO_DEPTH && !buf_read |=> ovr_q && cnt_q == 2'h3)
    else $error("overrun not flagged");
  AST_DEPTH: assert property (@(posedge clock) disable iff (reset) cnt_q <= SBG_FIFO_DEPTH)
    else $error("fifo count beyond three");
  AST_IRQ: assert property (@(posedge clock) disable iff (reset)
    clock_enable && irq_enable && (tif_d | rif_d) |=> irq)
    else $error("interrupt missing");
  AST_OFF: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !gen_enable |=> ts_q == SBG_IDLE && rs_q == SBG_IDLE)
    else $error("port active with generator off");
  AST_POP: assert property (@(posedge clock) disable iff (reset)
    clock_enable && pop && !rx_done && cnt_q >= 2'h2 |=> fifo_q[0] == $past(fifo_q[1]))
    else $error("fifo did not advance");
  AST_START: assert property (@(posedge clock) disable iff (reset)
    clock_enable && buf_write && gen_enable && ts_q == SBG_IDLE |=> ##1 tx_pin == 1'b0)
    else $error("start bit missing");
  COV_TX: cover property (@(posedge clock) $rose(tif_q));
  COV_RX: cover property (@(posedge clock) $rose(rif_q));
  COV_OVR: cover property (@(posedge clock) $rose(ovr_q));
endmodule

/* tb/sbg_remote_node.sv */
/*
  Remote serial node: sends 8N1 frames on rx_line, decodes tx_line.
  Assumes bit_cyc is set by the bench to the programmed bit period.
*/
`timescale 1ns/1ps
module sbg_remote_node (
  input wire logic clock,
  input wire logic tx_line,
  output logic rx_line
);
  int bit_cyc = 24;
  logic [7:0] got = 8'h00;
  logic stop_ok = 1'b0;

  initial rx_line = 1'b1;

  always begin
    @(negedge tx_line);
    repeat (bit_cyc / 2) @(posedge clock);
    for (int k = 0; k < 8; k++) begin
      repeat (bit_cyc) @(posedge clock);
      got[k] = tx_line;
    end
    repeat (bit_cyc) @(posedge clock);
    stop_ok = tx_line;
  end

  // Start low, LSB first, stop high; line held high between frames
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      @(negedge clock);
      rx_line = f[k];
      repeat (bit_cyc - 1) @(negedge clock);
    end
  endtask
endmodule

/* tb/sbg_serial_port_bench.sv */
/*
  Bench for the serial port: duplex frames at every prescaler and on the
  usb clock, FIFO overrun and flag clearing. Assumes sbg_remote_node.
*/
`timescale 1ns/1ps
module sbg_serial_port_bench;
  import sbg_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic usb_clock = 1'b0;
  logic clock_enable = 1'b1;
  logic gen_enable = 1'b0;
  logic gen_use_usb = 1'b0;
  logic [1:0] prescaler_select = SBG_PS_DIV1;
  logic [15:0] reload = 16'h0000;
  logic receive_enable = 1'b1;
  logic irq_enable = 1'b1;
  logic buf_write = 1'b0;
  logic [7:0] buf_wdata = 8'h00;
  logic buf_read = 1'b0;
  logic clear_tx_flag = 1'b0;
  logic clear_rx_flag = 1'b0;
  logic clear_overrun = 1'b0;
  logic rx_pin, tx_pin, tx_flag, rx_flag, ovr_flag, tx_busy, irq;
  logic [7:0] buf_rdata;
  int error_cnt = 0;
  int checks_done = 0;
  int pre_t[5] = '{1, 4, 12, 48, 1};
  int n_t[5] = '{12, 3, 1, 1, 6};

  always #2.5 clock = ~clock;
  // Rises every second core cycle
  always #5 usb_clock = ~usb_clock;

  sbg_serial_port dut (
    .clock, .reset, .clock_enable, .usb_clock, .gen_enable, .gen_use_usb,
    .prescaler_select, .baud_reload_high(reload[15:8]),
    .baud_reload_low(reload[7:0]), .receive_enable, .irq_enable,
    .buf_write, .buf_wdata, .buf_read, .clear_tx_flag, .clear_rx_flag,
    .clear_overrun, .rx_pin, .tx_pin, .buf_rdata,
    .transmit_complete_flag(tx_flag), .receive_flag(rx_flag),
    .receive_overrun_flag(ovr_flag), .tx_busy, .irq
  );

  sbg_remote_node rem (.clock, .tx_line(tx_pin), .rx_line(rx_pin));

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: return tx_flag;
      1: return rx_flag;
      default: return !tx_busy;
    endcase
  endfunction

  // Bounded wait; a hang ends the run
  task automatic wait_on(input int w);
    int i;
    for (i = 0; i < 4000 && sel(w) !== 1'b1; i++) @(negedge clock);
    if (i >= 4000) begin
      error_cnt++;
      conclude();
    end
  endtask

  task automatic pulse(input logic [3:0] m);
    @(negedge clock);
    {buf_read, clear_rx_flag, clear_tx_flag, clear_overrun} = m;
    @(negedge clock);
    {buf_read, clear_rx_flag, clear_tx_flag, clear_overrun} = 4'h0;
  endtask

  task automatic wr(input logic [7:0] b);
    @(negedge clock);
    buf_wdata = b;
    buf_write = 1'b1;
    @(negedge clock);
    buf_write = 1'b0;
  endtask

  // Bit = 2 * pre * (65536 - reload), twice that on the usb clock; never under 16 cycles
  task automatic cfg(input int i);
    @(negedge clock);
    gen_enable = 1'b0;
    prescaler_select = (i == 4) ? SBG_PS_DIV1 : i[1:0];
    gen_use_usb = (i == 4);
    reload = 16'(65536 - n_t[i]);
    rem.bit_cyc = 2 * pre_t[i] * n_t[i] * ((i == 4) ? 2 : 1);
    @(negedge clock);
    gen_enable = 1'b1;
  endtask

  task automatic t_reset();
    chk({tx_pin, tx_flag, rx_flag, ovr_flag, tx_busy, irq}, 6'h20);
  endtask

  // Send and receive at once; rx byte differs from tx byte
  task automatic t_duplex(input int i);
    logic [7:0] tb, rb;
    tb = 8'ha5 ^ i[7:0];
    rb = 8'h3c + i[7:0];
    cfg(i);
    fork
      rem.send(rb);
      wr(tb);
    join
    wait_on(0);
    @(negedge clock);
    chk(irq, 1'b1);
    wait_on(2);
    chk(rem.got, tb);
    chk(rem.stop_ok, 1'b1);
    wait_on(1);
    chk(buf_rdata, rb);
    chk(tx_flag, 1'b1);
    pulse(4'hc);
    chk(rx_flag, 1'b0);
    pulse(4'h2);
    chk(tx_flag, 1'b0);
  endtask

  // Four bytes into a three-byte FIFO, then drain
  task automatic t_fifo();
    int k;
    cfg(0);
    irq_enable = 1'b0;
    for (k = 0; k < 4; k++) rem.send(8'h51 + k[7:0]);
    repeat (48) @(negedge clock);
    chk(ovr_flag, 1'b1);
    chk(irq, 1'b0);
    for (k = 0; k < 3; k++) begin
      chk(buf_rdata, 8'h51 + k[7:0]);
      pulse(4'hc);
      chk(rx_flag, k < 2);
    end
    pulse(4'h1);
    chk(ovr_flag, 1'b0);
    irq_enable = 1'b1;
  endtask

  task automatic t_idle();
    @(negedge clock);
    gen_enable = 1'b0;
    wr(8'h5a);
    repeat (8) @(negedge clock);
    chk({tx_busy, tx_pin}, 2'h1);
  endtask

  initial begin
    repeat (2) @(negedge clock);
    reset = 1'b0;
    t_reset();
    // Each prescaler, then the usb clock
    for (int i = 0; i < 5; i++) t_duplex(i);
    t_fifo();
    t_idle();
    conclude();
  end
endmodule
